// ---- common/prot_params.svh ----
// Constants for the cell protection sequencer: timebase, delays,
// register indices, bit positions and bus answers.
// Assumes inclusion by bare name from any design file.
`ifndef CELL_PROT_PARAMS_SVH
`define CELL_PROT_PARAMS_SVH

// Timebase
`define CLK_PERIOD_NS 10
// Qualification delays in ns
`define T_OVERV_NS    1000000
`define T_UNDERV_NS   1000000
`define T_OVERI_NS    10000
`define T_SHORT_NS    1000

// Register indices; byte address is four times the index
`define IDX_PROT      6'h00
`define IDX_STAT      6'h01
`define IDX_SPEC      6'h08

// Protection register bits
`define PB_OVERV      7
`define PB_UNDERV     6
`define PB_OVERI      4
`define PB_CHGSW      3
`define PB_DISSW      2
`define PB_CHGEN      1
`define PB_DISEN      0
// Status register bits
`define SB_ACTIVE     0
`define SB_TEST       1
`define SB_RECOV      2
// Special feature register bits
`define FB_PWRSW      7
`define FB_HOT        0

// AXI responses
`define RESP_OKAY     2'h0
`define RESP_DECERR   2'h3

`endif

// ---- common/prot_pkg.sv ----
// Types shared by the cell protection sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package prot_pkg;

    // Power modes, one-hot
    typedef enum logic [1:0] {
        MODE_SLEEP  = 2'b01,
        MODE_ACTIVE = 2'b10
    } mode_t;

    // Comparator and sense inputs
    typedef struct packed {
        logic above_ovt;  // Cell above overvoltage threshold
        logic below_uvt;  // Cell below undervoltage threshold
        logic below_dep;  // Cell below depletion threshold
        logic below_cet;  // Cell below charge-enable threshold
        logic drop_high;  // Switch drop above overcurrent threshold
        logic chgr_seen;  // Pack above cell plus charger margin
        logic pack_back;  // Pack above cell minus overcurrent margin
        logic too_hot;    // Die above temperature limit
        logic pwr_sw_n;   // Power-switch sense, low when closed
    } cmp_t;

endpackage

// ---- common/qual_if.sv ----
// Link between the sequencer and one delay qualifier.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface qual_if;
    logic cond;
    logic bypass;
    logic fired;
    modport ctl (output cond, output bypass, input fired);
    modport tmr (input cond, input bypass, output fired);
endinterface

// ---- core/cell_protect.sv ----
// Protection sequencer for one lithium cell with an AXI4-Lite register port.
// Assumes comparator results arrive asynchronously and switch drivers follow
// the control outputs directly.
//
// Summary of operation
// - Two power modes, active and sleep; monitoring runs continuously while active.
// - Sleep stops monitoring and holds both switch controls off.
// - Waking restarts monitoring; switches turn on only if no fault forbids.
// - Wake on power-switch sense closed or pack above cell plus charger margin.
// - Never enter active while the cell is at or below depletion.
// - Overvoltage past its delay turns charge off, sets flag, keeps discharge.
// - Charge returns when cell below charge-enable or switch drop high.
// - Overvoltage qualification delay is zero on the sleep-to-active step.
// - Undervoltage past its delay turns both off, sets flag, enters sleep.
// - After undervoltage, switches return only with cell above limit and charger.
// - Depletion past short delay turns both off, sets overcurrent flag, until pack recovers.
// - After a short, once above depletion, enable test current and recovery path.
// - Overcurrent past its delay turns both off, sets flag, starts test current.
// - Overtemperature turns both off at once; on again after cool and cleared flag.
// - Fault flags stay set until the host clears them.
// - Allow bits force switches off at zero; set to one on wake.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "prot_params.svh"
module cell_protect #(
    parameter int OVD_CYC = `T_OVERV_NS / `CLK_PERIOD_NS,
    parameter int UVD_CYC = `T_UNDERV_NS / `CLK_PERIOD_NS,
    parameter int OCD_CYC = `T_OVERI_NS / `CLK_PERIOD_NS,
    parameter int SCD_CYC = `T_SHORT_NS / `CLK_PERIOD_NS
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire prot_pkg::cmp_t cmp_in,
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [7:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic               charge_switch_ctrl,
    output logic               discharge_switch_ctrl,
    output logic               test_pullup_current,
    output logic               recovery_charge_en
);
    typedef struct packed {
        prot_pkg::mode_t mode;
        prot_pkg::cmp_t  sync1;
        prot_pkg::cmp_t  sync2;
        logic            waking;
        logic            over_voltage_flag;
        logic            under_voltage_flag;
        logic            over_current_flag;
        logic            over_temp_flag;
        logic            pwr_sw_flag;
        logic            charge_allow_bit;
        logic            discharge_allow_bit;
        logic            hv_hold;
        logic            fault_hold;
        logic            dep_hold;
        logic            lv_hold;
        logic            chg_sw;
        logic            dis_sw;
        logic            tst;
        logic            rec;
        logic            awready;
        logic            wready;
        logic            aw_got;
        logic            w_got;
        logic [5:0]      waddr;
        logic [7:0]      wbyte;
        logic            wlane;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [1:0]      rresp;
        logic [31:0]     rdata;
    } st_t;

    st_t st_ff;
    st_t nxt_st;

    qual_if hv_q ();
    qual_if lv_q ();
    qual_if oc_q ();
    qual_if sc_q ();

    prot_pkg::cmp_t s;
    logic           active;
    logic           wr_do;
    logic           wr_prot;
    logic           wr_spec;
    logic [5:0]     rd_idx;

    assign s       = st_ff.sync2;
    assign active  = (st_ff.mode == prot_pkg::MODE_ACTIVE);
    assign wr_do   = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
    assign wr_prot = wr_do && st_ff.wlane && (st_ff.waddr == `IDX_PROT);
    assign wr_spec = wr_do && st_ff.wlane && (st_ff.waddr == `IDX_SPEC);
    assign rd_idx  = s_axi_araddr[7:2];

    assign hv_q.cond   = active && s.above_ovt;
    assign hv_q.bypass = st_ff.waking;
    assign lv_q.cond   = active && s.below_uvt && !s.below_dep;
    assign lv_q.bypass = 1'b0;
    assign oc_q.cond   = active && s.drop_high;
    assign oc_q.bypass = 1'b0;
    assign sc_q.cond   = active && s.below_dep;
    assign sc_q.bypass = 1'b0;

    // Delay qualifiers
    qual_timer #(.LIMIT(OVD_CYC)) u_hv (.aclk(aclk), .aresetn(aresetn), .q(hv_q));
    qual_timer #(.LIMIT(UVD_CYC)) u_lv (.aclk(aclk), .aresetn(aresetn), .q(lv_q));
    qual_timer #(.LIMIT(OCD_CYC)) u_oc (.aclk(aclk), .aresetn(aresetn), .q(oc_q));
    qual_timer #(.LIMIT(SCD_CYC)) u_sc (.aclk(aclk), .aresetn(aresetn), .q(sc_q));

    // Next state: sync, bus, host writes, then hardware events (set wins)
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.sync1  = cmp_in;
        nxt_st.sync2  = st_ff.sync1;
        nxt_st.waking = 1'b0;

        // Write address and data taken in either order
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.waddr  = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wbyte = s_axi_wdata[7:0];
            nxt_st.wlane = s_axi_wstrb[0];
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (wr_do) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = (st_ff.waddr == `IDX_PROT || st_ff.waddr == `IDX_STAT
                             || st_ff.waddr == `IDX_SPEC) ? `RESP_OKAY : `RESP_DECERR;
        end
        if (wr_prot) begin
            nxt_st.over_voltage_flag   = st_ff.wbyte[`PB_OVERV];
            nxt_st.under_voltage_flag  = st_ff.wbyte[`PB_UNDERV];
            nxt_st.over_current_flag   = st_ff.wbyte[`PB_OVERI];
            nxt_st.charge_allow_bit    = st_ff.wbyte[`PB_CHGEN];
            nxt_st.discharge_allow_bit = st_ff.wbyte[`PB_DISEN];
        end
        if (wr_spec) begin
            nxt_st.pwr_sw_flag    = st_ff.wbyte[`FB_PWRSW];
            nxt_st.over_temp_flag = st_ff.wbyte[`FB_HOT];
        end

        // Read channel
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = '0;
            nxt_st.rresp  = `RESP_OKAY;
            unique case (rd_idx)
                `IDX_PROT: begin
                    nxt_st.rdata[`PB_OVERV]  = st_ff.over_voltage_flag;
                    nxt_st.rdata[`PB_UNDERV] = st_ff.under_voltage_flag;
                    nxt_st.rdata[`PB_OVERI]  = st_ff.over_current_flag;
                    nxt_st.rdata[`PB_CHGSW]  = st_ff.chg_sw;
                    nxt_st.rdata[`PB_DISSW]  = st_ff.dis_sw;
                    nxt_st.rdata[`PB_CHGEN]  = st_ff.charge_allow_bit;
                    nxt_st.rdata[`PB_DISEN]  = st_ff.discharge_allow_bit;
                end
                `IDX_STAT: begin
                    nxt_st.rdata[`SB_ACTIVE] = active;
                    nxt_st.rdata[`SB_TEST]   = st_ff.tst;
                    nxt_st.rdata[`SB_RECOV]  = st_ff.rec;
                end
                `IDX_SPEC: begin
                    nxt_st.rdata[`FB_PWRSW] = st_ff.pwr_sw_flag;
                    nxt_st.rdata[`FB_HOT]   = st_ff.over_temp_flag;
                end
                default: begin
                    nxt_st.rresp = `RESP_DECERR;
                end
            endcase
        end

        // Power-switch closure clears its flag in any mode
        if (!s.pwr_sw_n) begin
            nxt_st.pwr_sw_flag = 1'b0;
        end

        // Mode sequencing
        unique case (st_ff.mode)
            prot_pkg::MODE_SLEEP: begin
                // wake sources; refused at depletion; after undervoltage
                if ((!s.pwr_sw_n || s.chgr_seen) && !s.below_dep
                    && (!st_ff.lv_hold || (s.chgr_seen && !s.below_uvt))) begin
                    nxt_st.mode                = prot_pkg::MODE_ACTIVE;
                    nxt_st.waking              = 1'b1;
                    nxt_st.lv_hold             = 1'b0;
                    nxt_st.charge_allow_bit    = 1'b1;
                    nxt_st.discharge_allow_bit = 1'b1;
                end
            end
            prot_pkg::MODE_ACTIVE: begin
                if (lv_q.fired) begin
                    nxt_st.mode               = prot_pkg::MODE_SLEEP;
                    nxt_st.under_voltage_flag = 1'b1;
                    nxt_st.lv_hold            = 1'b1;
                end
            end
        endcase

        if (hv_q.fired) begin
            nxt_st.over_voltage_flag = 1'b1;
            nxt_st.hv_hold           = 1'b1;
        end else if (st_ff.hv_hold && (s.below_cet || s.drop_high)) begin
            nxt_st.hv_hold = 1'b0;
        end

        if (oc_q.fired || sc_q.fired) begin
            nxt_st.over_current_flag = 1'b1;
            nxt_st.fault_hold        = 1'b1;
            nxt_st.dep_hold          = st_ff.dep_hold || sc_q.fired;
        end else if (st_ff.fault_hold && s.pack_back) begin
            nxt_st.fault_hold = 1'b0;
            nxt_st.dep_hold   = 1'b0;
        end

        if (active && s.too_hot) begin
            nxt_st.over_temp_flag = 1'b1;
        end

        // test current after an overcurrent or a short; recovery path after a short or below charge-enable
        nxt_st.tst = active && nxt_st.fault_hold && !(nxt_st.dep_hold && s.below_dep);
        nxt_st.rec = active && ((nxt_st.dep_hold && !s.below_dep) || s.below_cet);

        // sleep forces off; conditional switch on
        nxt_st.chg_sw = active && !st_ff.waking && nxt_st.charge_allow_bit
                        && !nxt_st.hv_hold && !nxt_st.fault_hold
                        && !nxt_st.over_temp_flag && !s.too_hot;
        nxt_st.dis_sw = active && nxt_st.discharge_allow_bit && !nxt_st.fault_hold
                        && !nxt_st.over_temp_flag && !s.too_hot;

        // Ready outputs registered from the next occupancy
        nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
        nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;
        nxt_st.arready = !nxt_st.rvalid;
    end

    // State register with synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff                     <= '0;
            st_ff.mode                <= prot_pkg::MODE_SLEEP;
            st_ff.sync1.pwr_sw_n      <= 1'b1;
            st_ff.sync2.pwr_sw_n      <= 1'b1;
            st_ff.under_voltage_flag  <= 1'b1;
            st_ff.over_current_flag   <= 1'b1;
            st_ff.pwr_sw_flag         <= 1'b1;
            st_ff.charge_allow_bit    <= 1'b1;
            st_ff.discharge_allow_bit <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready         = st_ff.awready;
    assign s_axi_wready          = st_ff.wready;
    assign s_axi_bvalid          = st_ff.bvalid;
    assign s_axi_bresp           = st_ff.bresp;
    assign s_axi_arready         = st_ff.arready;
    assign s_axi_rvalid          = st_ff.rvalid;
    assign s_axi_rresp           = st_ff.rresp;
    assign s_axi_rdata           = st_ff.rdata;
    assign charge_switch_ctrl    = st_ff.chg_sw;
    assign discharge_switch_ctrl = st_ff.dis_sw;
    assign test_pullup_current   = st_ff.tst;
    assign recovery_charge_en    = st_ff.rec;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_sleep_switches_off: assert property (!active |=> !charge_switch_ctrl && !discharge_switch_ctrl)
        else $error("switch on while asleep");
    a_no_wake_depleted: assert property (!active && s.below_dep |=> !active)
        else $error("woke while depleted");
    a_hv_charge_off: assert property (hv_q.fired |=> !charge_switch_ctrl && st_ff.over_voltage_flag)
        else $error("overvoltage left charge on");
    a_lv_to_sleep: assert property (active && lv_q.fired |=> !active ##1 !charge_switch_ctrl && !discharge_switch_ctrl)
        else $error("undervoltage did not sleep");
    a_fault_both_off: assert property (oc_q.fired || sc_q.fired |=> st_ff.over_current_flag ##0 !charge_switch_ctrl && !discharge_switch_ctrl)
        else $error("overcurrent left a switch on");
    a_hot_both_off: assert property (s.too_hot |=> !charge_switch_ctrl && !discharge_switch_ctrl)
        else $error("overtemperature left a switch on");
    a_wake_allow_set: assert property ($rose(active) |-> st_ff.charge_allow_bit && st_ff.discharge_allow_bit)
        else $error("allow bits not set on wake");
    a_flag_sticky: assert property (st_ff.over_voltage_flag && !wr_prot |=> st_ff.over_voltage_flag)
        else $error("overvoltage flag cleared itself");
    a_short_test_on: assert property (active && st_ff.dep_hold && st_ff.fault_hold && !s.below_dep && !s.pack_back && !lv_q.fired |=> test_pullup_current && recovery_charge_en)
        else $error("no test current after short");

    c_wake: cover property ($rose(active));
    c_hv_trip: cover property (hv_q.fired ##1 !charge_switch_ctrl);
    c_short_recovery: cover property (sc_q.fired ##[1:50] recovery_charge_en);
    c_hot_trip: cover property (active && s.too_hot);
endmodule

// ---- core/qual_timer.sv ----
// Delay qualifier: fires once its condition has held past the limit.
// Assumes a synchronous condition on the same clock.
`timescale 1ns/1ps
module qual_timer #(
    parameter int LIMIT = 1
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    qual_if.tmr       q
);
    localparam int W = $clog2(LIMIT + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         fired;
    } qst_t;

    qst_t st_ff;
    qst_t nxt_st;

    // Count while the condition holds, restart when it drops
    always_comb begin
        nxt_st = st_ff;
        if (!q.cond) begin
            nxt_st.cnt   = '0;
            nxt_st.fired = 1'b0;
        end else if (q.bypass) begin
            nxt_st.fired = 1'b1;
        end else if (st_ff.cnt == W'(LIMIT)) begin
            nxt_st.fired = 1'b1;
        end else begin
            nxt_st.cnt = W'(st_ff.cnt + 1'b1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q.fired = st_ff.fired;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_bypass_fires: assert property (q.cond && q.bypass |=> q.fired)
        else $error("bypassed condition did not fire at once");
    a_drop_restart: assert property (!q.cond |=> !q.fired && st_ff.cnt == '0)
        else $error("qualifier did not restart on deassert");
endmodule

// ---- tb/cell_front.sv ----
// Far-side model: comparators, temperature sensor, switch sense.
// Assumes millivolt levels from the bench; results settle on aclk.
`timescale 1ns/1ps
module cell_front #(
    parameter int OV_MV = 4300,
    parameter int CE_MV = 3500,
    parameter int UV_MV = 2500,
    parameter int SC_MV = 1500,
    parameter int CH_MV = 300,
    parameter int OC_MV = 200
) (
    input  wire logic        aclk,
    input  wire logic [15:0] cell_mv,
    input  wire logic [15:0] pack_mv,
    input  wire logic        hot,
    input  wire logic        sw_closed,
    output prot_pkg::cmp_t   cmp
);
    int c;
    int p;
    assign c = int'(cell_mv);
    assign p = int'(pack_mv);
    // Comparator decisions, one clock of analog settling
    always_ff @(posedge aclk) begin
        cmp.above_ovt <= c > OV_MV;
        cmp.below_uvt <= c < UV_MV;
        cmp.below_dep <= c < SC_MV;
        cmp.below_cet <= c < CE_MV;
        cmp.drop_high <= c - p > OC_MV;
        cmp.chgr_seen <= p > c + CH_MV;
        cmp.pack_back <= p > c - OC_MV;
        cmp.too_hot   <= hot;
        cmp.pwr_sw_n  <= !sw_closed; // Pull-up when open
    end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the cell protection sequencer.
// Assumes registered bus answers and a two-flop input sync in the design.
`timescale 1ns/1ps
module testbench;
    localparam int OVD = 8;
    localparam int UVD = 8;
    localparam int OCD = 6;
    localparam int SCD = 4;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hot, sw_closed;
    logic awready, wready, bvalid, arready, rvalid, chg, dis, tst, rec;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] cell_mv, pack_mv;
    prot_pkg::cmp_t cmp;
    int errors, n_checks, seed;
    // Free-running 100 MHz clock
    always #5 aclk = ~aclk;
    cell_protect #(.OVD_CYC(OVD), .UVD_CYC(UVD), .OCD_CYC(OCD), .SCD_CYC(SCD)) cell_protect_i (
        .aclk(aclk), .aresetn(aresetn), .cmp_in(cmp),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .charge_switch_ctrl(chg), .discharge_switch_ctrl(dis),
        .test_pullup_current(tst), .recovery_charge_en(rec));
    cell_front cell_front_i (.aclk(aclk), .cell_mv(cell_mv), .pack_mv(pack_mv),
        .hot(hot), .sw_closed(sw_closed), .cmp(cmp));
    // Expected protection word from flags, switch states, allow bits
    function automatic logic [31:0] pw(input logic [2:0] f, input logic [1:0] s, input logic [1:0] al);
        return {24'h0, f[2:1], 1'b0, f[0], s, al};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic sw(input logic c, input logic d);
        chk("charge", {31'h0, c}, {31'h0, chg});
        chk("discharge", {31'h0, d}, {31'h0, dis});
    endtask
    task automatic lv(input int c, input int p);
        cell_mv <= c[15:0];
        pack_mv <= p[15:0];
    endtask
    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        chk("rdata", ed, rdata);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        close_out();
    end
    // Main sequence
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hot, sw_closed} = '0;
        {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
        {cell_mv, pack_mv} = {16'h0e74, 16'h0e74};
        {errors, n_checks, seed} = {32'h0, 32'h0, 32'hcb99d366};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        tick(2);
        rd(8'h00, pw(3'b011, 2'b00, 2'b11), 2'h0);
        sw(1'b0, 1'b0);
        rd(8'h04, 32'h0, 2'h0);
        rd(8'h08, 32'h0, 2'h3);
        wr(8'h0c, 32'hff, 2'h3);
        $display("test reset done");
        lv(3700, 4100);
        tick(8);
        sw(1'b1, 1'b1);
        rd(8'h04, 32'h1, 2'h0);
        lv(3700, 3700);
        wr(8'h00, 32'h3, 2'h0);
        rd(8'h00, pw(3'b000, 2'b11, 2'b11), 2'h0);
        $display("test wake done");
        repeat (6) begin
            v = $random(seed);
            wr(8'h00, {30'h0, v[1:0]}, 2'h0);
            tick(4);
            sw(v[1], v[0]);
        end
        wr(8'h00, 32'h3, 2'h0);
        $display("test allow done");
        lv(4400, 4400);
        tick(OVD / 2);
        lv(3700, 3700);
        tick(OVD + 8);
        sw(1'b1, 1'b1);
        lv(4400, 4400);
        tick(OVD + 8);
        sw(1'b0, 1'b1);
        lv(3400, 3400);
        tick(6);
        sw(1'b1, 1'b1);
        rd(8'h00, pw(3'b100, 2'b11, 2'b11), 2'h0);
        lv(3700, 3700);
        wr(8'h00, 32'h3, 2'h0);
        $display("test overvoltage done");
        hot <= 1'b1;
        tick(6);
        sw(1'b0, 1'b0);
        hot <= 1'b0;
        tick(6);
        sw(1'b0, 1'b0);
        wr(8'h20, 32'h80, 2'h0);
        tick(4);
        sw(1'b1, 1'b1);
        $display("test overtemp done");
        lv(3700, 3400);
        tick(OCD + 8);
        sw(1'b0, 1'b0);
        chk("test_current", 32'h1, {31'h0, tst});
        rd(8'h00, pw(3'b001, 2'b00, 2'b11), 2'h0);
        lv(3700, 3650);
        tick(6);
        sw(1'b1, 1'b1);
        chk("test_current", 32'h0, {31'h0, tst});
        wr(8'h00, 32'h3, 2'h0);
        $display("test overcurrent done");
        lv(1000, 1000);
        tick(SCD + 8);
        sw(1'b0, 1'b0);
        lv(2600, 1000);
        tick(6);
        chk("test_current", 32'h1, {31'h0, tst});
        chk("recovery", 32'h1, {31'h0, rec});
        lv(2600, 2500);
        tick(6);
        sw(1'b1, 1'b1);
        $display("test short done");
        lv(2000, 2000);
        tick(UVD + 8);
        sw(1'b0, 1'b0);
        rd(8'h04, 32'h0, 2'h0);
        lv(3700, 3700);
        sw_closed <= 1'b1;
        tick(8);
        sw(1'b0, 1'b0);
        sw_closed <= 1'b0;
        lv(3700, 4100);
        tick(8);
        sw(1'b1, 1'b1);
        $display("test undervoltage done");
        // Mid-run reset, then wake attempts while depleted and while overcharged
        aresetn <= 1'b0;
        lv(1000, 1000);
        sw_closed <= 1'b1;
        tick(2);
        aresetn <= 1'b1;
        tick(8);
        sw(1'b0, 1'b0);
        rd(8'h04, 32'h0, 2'h0);
        lv(4400, 4400);
        tick(8);
        sw(1'b0, 1'b1);
        rd(8'h00, pw(3'b111, 2'b01, 2'b11), 2'h0);
        rd(8'h20, 32'h0, 2'h0);
        wstrb <= 4'he;
        wr(8'h00, 32'h0, 2'h0);
        wstrb <= 4'hf;
        rd(8'h00, pw(3'b111, 2'b01, 2'b11), 2'h0);
        $display("test depleted wake done");
        close_out();
    end
endmodule
